// file: bdq_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and a fill count
`timescale 1ns/1ns
module bdq_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] fill_count
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } bdq_fifo_state_type;

  bdq_fifo_state_type state;
  bdq_fifo_state_type next_state;

  // ---------------------------------------------------------------
  // Status
  // ---------------------------------------------------------------
  // Extra pointer bit tells a full ring from an empty one
  assign fill_count = state.wr_ptr - state.rd_ptr;
  assign in_ready = (fill_count != (AW + 1)'(DEPTH));
  assign out_valid = (fill_count != '0);
  assign out_data = state.mem[state.rd_ptr[AW-1:0]];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    if (in_valid && in_ready)
    begin
      next_state.mem[state.wr_ptr[AW-1:0]] = in_data;
      next_state.wr_ptr = state.wr_ptr + 1'b1;
    end
    if (out_valid && out_ready)
    begin
      next_state.rd_ptr = state.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_no_overflow_push: assert property (@(posedge clk) disable iff (!reset_n)
    (!in_ready && !(out_valid && out_ready)) |=> $stable(state.wr_ptr))
    else $error("write pointer moved while full");

endmodule : bdq_fifo

// file: bdq_pkg.sv
// Shared constants and helpers for the bidirectional queue port block
package bdq_pkg;

  // ---------------------------------------------------------------
  // Data path shape
  // ---------------------------------------------------------------
  localparam int BDQ_WIDTH = 36;
  localparam int BDQ_DEPTH = 64;
  localparam int BDQ_COUNT_W = 7;
  localparam logic [6:0] BDQ_COUNT_FULL = 7'h40;
  localparam logic [6:0] BDQ_COUNT_EMPTY = 7'h00;

  // ---------------------------------------------------------------
  // Almost-full / almost-empty offset choices
  // ---------------------------------------------------------------
  localparam logic [6:0] BDQ_OFFSET_HH = 7'h10;
  localparam logic [6:0] BDQ_OFFSET_HL = 7'h0C;
  localparam logic [6:0] BDQ_OFFSET_LH = 7'h08;
  localparam logic [6:0] BDQ_OFFSET_LL = 7'h04;
  localparam logic [6:0] BDQ_OFFSET_RESET = 7'h04;

  // ---------------------------------------------------------------
  // Reset values of the two-stage flag chains and mail flags
  // ---------------------------------------------------------------
  localparam logic [1:0] BDQ_SYNC_LOW_RESET = 2'h0;
  localparam logic [1:0] BDQ_SYNC_HIGH_RESET = 2'h3;
  localparam logic BDQ_MAIL_FLAG_RESET = 1'h1;
  localparam logic [35:0] BDQ_DATA_RESET = 36'h000000000;

  // Offset table indexed by {select_hi, select_lo}
  function automatic logic [6:0] bdq_offset_decode(input logic sel_hi, input logic sel_lo);
    logic [6:0] value;
    value = BDQ_OFFSET_LL;
    case ({sel_hi, sel_lo})
      2'h3: value = BDQ_OFFSET_HH;
      2'h2: value = BDQ_OFFSET_HL;
      2'h1: value = BDQ_OFFSET_LH;
      default: value = BDQ_OFFSET_LL;
    endcase
    return value;
  endfunction : bdq_offset_decode

endpackage : bdq_pkg

// file: bdq_port_host.sv
// Port host model: free-running port clock and the resolved data bus
`timescale 1ns/1ns
module bdq_port_host #(
  parameter int HALF = 2
) (
  input wire logic clk,
  input wire logic [bdq_pkg::BDQ_WIDTH-1:0] data_out,
  input wire logic data_oe_n,
  output logic port_clock,
  output logic [bdq_pkg::BDQ_WIDTH-1:0] bus_level
);
  import bdq_pkg::*;
  int cnt = 0;
  logic [BDQ_WIDTH-1:0] last = '0;
  initial port_clock = 1'b0;
  // ---------------------------------------------------------------
  // Clock and bus
  // ---------------------------------------------------------------
  // Port clock never stops, so a reset always sees its edges
  always @(negedge clk)
  begin
    if (cnt == HALF - 1)
    begin
      cnt <= 0;
      port_clock <= ~port_clock;
    end
    else
      cnt <= cnt + 1;
  end
  always @(posedge clk)
    if (!data_oe_n)
      last <= data_out;
  // Released bus shows the inverse of its last value, so stale data never matches
  assign bus_level = data_oe_n ? ~last : data_out;
endmodule : bdq_port_host

// file: bdq_ports.sv
// Two opposing 64x36 queues with mailboxes between a left and a right port
//
// What this block does
// - Reset acts asynchronously to both port clocks
// - Reset clears pointers, sets documented flag levels
// - Full flag rises on second port edge
// - Reset release latches offset from select inputs
// - Left bus drives only when selected and reading
// - Left bus shows reverse mailbox or queue output
// - Left enabled write stores word in forward queue
// - Left enabled read advances reverse queue output
// - Left mailbox access writes forward or reads reverse
// - Right bus drives only when selected and reading
// - Right enabled write stores word in reverse queue
// - Right enabled read advances forward queue output
// - Right size both high addresses the mailboxes
// - Enable low means no transfer that edge
// - Each queue status flag passes two port-clocked stages
// - Each queue flag steps on its own port clock
// - Forward queue thresholds for empty, almost, full
// - Reverse queue uses same thresholds, ports swapped
// - Read while empty is ignored
// - Write while full is ignored
// - Mailbox write locks until opposite side reads
`timescale 1ns/1ns
module bdq_ports (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic left_port_clock,
  input wire logic right_port_clock,
  input wire logic offset_select_lo,
  input wire logic offset_select_hi,
  input wire logic left_chip_select_n,
  input wire logic left_write_not_read,
  input wire logic left_port_enable,
  input wire logic left_mailbox_select,
  input wire logic [bdq_pkg::BDQ_WIDTH-1:0] left_data_in,
  output logic [bdq_pkg::BDQ_WIDTH-1:0] left_data_out,
  output logic left_data_oe_n,
  input wire logic right_chip_select_n,
  input wire logic right_write_not_read,
  input wire logic right_port_enable,
  input wire logic right_size_select_lo,
  input wire logic right_size_select_hi,
  input wire logic [bdq_pkg::BDQ_WIDTH-1:0] right_data_in,
  output logic [bdq_pkg::BDQ_WIDTH-1:0] right_data_out,
  output logic right_data_oe_n,
  output logic left_full_n,
  output logic left_almost_full_n,
  output logic left_empty_n,
  output logic left_almost_empty_n,
  output logic right_full_n,
  output logic right_almost_full_n,
  output logic right_empty_n,
  output logic right_almost_empty_n,
  output logic fwd_mail_flag_n,
  output logic rev_mail_flag_n
);
  import bdq_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic left_clock_prev;
    logic right_clock_prev;
    logic offset_loaded;
    logic [6:0] offset;
    logic [1:0] left_full_sync;
    logic [1:0] left_af_sync;
    logic [1:0] left_empty_sync;
    logic [1:0] left_ae_sync;
    logic [1:0] right_full_sync;
    logic [1:0] right_af_sync;
    logic [1:0] right_empty_sync;
    logic [1:0] right_ae_sync;
    logic [35:0] forward_mailbox;
    logic [35:0] reverse_mailbox;
    logic [35:0] left_out_reg;
    logic [35:0] right_out_reg;
    logic fwd_mail_flag_n;
    logic rev_mail_flag_n;
  } bdq_core_type;

  bdq_core_type core;
  bdq_core_type next_core;

  // Port edge strobes, one clk cycle wide
  logic left_edge;
  logic right_edge;
  logic left_access;
  logic right_access;
  logic right_mailbox_select;

  // Decoded transfer requests
  logic fwd_push;
  logic fwd_pop;
  logic rev_push;
  logic rev_pop;
  logic fwd_mail_write;
  logic fwd_mail_read;
  logic rev_mail_write;
  logic rev_mail_read;

  // Queue handshakes
  logic fwd_in_ready;
  logic fwd_out_valid;
  logic [BDQ_WIDTH-1:0] fwd_out_data;
  logic [BDQ_COUNT_W-1:0] fwd_count;
  logic rev_out_valid;
  logic [BDQ_WIDTH-1:0] rev_out_data;
  logic [BDQ_COUNT_W-1:0] rev_count;

  // Raw flag levels before the two port-clocked stages
  logic fwd_full_raw;
  logic fwd_af_raw;
  logic fwd_empty_raw;
  logic fwd_ae_raw;
  logic rev_full_raw;
  logic rev_af_raw;
  logic rev_empty_raw;
  logic rev_ae_raw;

  // Shift a flag chain only on its own port edge
  function automatic logic [1:0] sync_step(input logic step, input logic [1:0] chain,
                                          input logic raw);
    return step ? {chain[0], raw} : chain;
  endfunction : sync_step

  // ---------------------------------------------------------------
  // Port decode
  // ---------------------------------------------------------------
  // Port clocks are sampled as data, so an edge is a one-cycle strobe
  assign left_edge = left_port_clock && !core.left_clock_prev;
  assign right_edge = right_port_clock && !core.right_clock_prev;

  assign left_access = left_edge && !left_chip_select_n && left_port_enable;
  assign right_access = right_edge && !right_chip_select_n && right_port_enable;
  // both size selects high pick the mailboxes
  assign right_mailbox_select = right_size_select_hi && right_size_select_lo;

  // forward write needs full flag high
  assign fwd_push = left_access && left_write_not_read && !left_mailbox_select
                    && left_full_n;
  // reverse read needs empty flag high
  assign rev_pop = left_access && !left_write_not_read && !left_mailbox_select
                   && left_empty_n;
  assign fwd_mail_write = left_access && left_write_not_read && left_mailbox_select
                          && core.fwd_mail_flag_n;
  assign rev_mail_read = left_access && !left_write_not_read && left_mailbox_select;
  assign rev_push = right_access && right_write_not_read && !right_mailbox_select
                    && right_full_n;
  // forward read needs empty flag high
  assign fwd_pop = right_access && !right_write_not_read && !right_mailbox_select
                   && right_empty_n;
  assign rev_mail_write = right_access && right_write_not_read && right_mailbox_select
                          && core.rev_mail_flag_n;
  assign fwd_mail_read = right_access && !right_write_not_read && right_mailbox_select;

  // ---------------------------------------------------------------
  // Queues
  // ---------------------------------------------------------------
  // pointer pair with wrap bit inside each queue
  bdq_fifo #(
    .WIDTH(BDQ_WIDTH),
    .DEPTH(BDQ_DEPTH)
  ) forward_queue (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(fwd_push),
    .in_ready(fwd_in_ready),
    .in_data(left_data_in),
    .out_valid(fwd_out_valid),
    .out_ready(fwd_pop),
    .out_data(fwd_out_data),
    .fill_count(fwd_count)
  );

  bdq_fifo #(
    .WIDTH(BDQ_WIDTH),
    .DEPTH(BDQ_DEPTH)
  ) reverse_queue (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(rev_push),
    .in_ready(),
    .in_data(right_data_in),
    .out_valid(rev_out_valid),
    .out_ready(rev_pop),
    .out_data(rev_out_data),
    .fill_count(rev_count)
  );

  // ---------------------------------------------------------------
  // Raw flag levels
  // ---------------------------------------------------------------
  // forward and reverse queue thresholds
  assign fwd_full_raw = (fwd_count != BDQ_COUNT_FULL);
  assign fwd_af_raw = (fwd_count < 7'(BDQ_COUNT_FULL - core.offset));
  assign fwd_empty_raw = (fwd_count != BDQ_COUNT_EMPTY);
  assign fwd_ae_raw = (fwd_count > core.offset);
  assign rev_full_raw = (rev_count != BDQ_COUNT_FULL);
  assign rev_af_raw = (rev_count < 7'(BDQ_COUNT_FULL - core.offset));
  assign rev_empty_raw = (rev_count != BDQ_COUNT_EMPTY);
  assign rev_ae_raw = (rev_count > core.offset);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_core = core;
    next_core.left_clock_prev = left_port_clock;
    next_core.right_clock_prev = right_port_clock;
    // offset caught on the first cycle after reset release
    if (!core.offset_loaded)
    begin
      next_core.offset_loaded = 1'b1;
      next_core.offset = bdq_offset_decode(offset_select_hi, offset_select_lo);
    end
    // left flags step on left edges, right on right edges
    next_core.left_full_sync = sync_step(left_edge, core.left_full_sync, fwd_full_raw);
    next_core.left_af_sync = sync_step(left_edge, core.left_af_sync, fwd_af_raw);
    next_core.left_empty_sync = sync_step(left_edge, core.left_empty_sync, rev_empty_raw);
    next_core.left_ae_sync = sync_step(left_edge, core.left_ae_sync, rev_ae_raw);
    next_core.right_full_sync = sync_step(right_edge, core.right_full_sync, rev_full_raw);
    next_core.right_af_sync = sync_step(right_edge, core.right_af_sync, rev_af_raw);
    next_core.right_empty_sync = sync_step(right_edge, core.right_empty_sync, fwd_empty_raw);
    next_core.right_ae_sync = sync_step(right_edge, core.right_ae_sync, fwd_ae_raw);
    // output register moves only on a real pop
    if (rev_pop && rev_out_valid)
    begin
      next_core.left_out_reg = rev_out_data;
    end
    if (fwd_pop && fwd_out_valid)
    begin
      next_core.right_out_reg = fwd_out_data;
    end
    // a read reopens the mailbox, a same-cycle write wins
    if (fwd_mail_read)
    begin
      next_core.fwd_mail_flag_n = 1'b1;
    end
    if (fwd_mail_write)
    begin
      next_core.forward_mailbox = left_data_in;
      next_core.fwd_mail_flag_n = 1'b0;
    end
    if (rev_mail_read)
    begin
      next_core.rev_mail_flag_n = 1'b1;
    end
    if (rev_mail_write)
    begin
      next_core.reverse_mailbox = right_data_in;
      next_core.rev_mail_flag_n = 1'b0;
    end
  end

  // pointers cleared, flags forced to reset levels
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      core.left_clock_prev <= 1'b1;
      core.right_clock_prev <= 1'b1;
      core.offset_loaded <= 1'b0;
      core.offset <= BDQ_OFFSET_RESET;
      core.left_full_sync <= BDQ_SYNC_LOW_RESET;
      core.left_af_sync <= BDQ_SYNC_HIGH_RESET;
      core.left_empty_sync <= BDQ_SYNC_LOW_RESET;
      core.left_ae_sync <= BDQ_SYNC_LOW_RESET;
      core.right_full_sync <= BDQ_SYNC_LOW_RESET;
      core.right_af_sync <= BDQ_SYNC_HIGH_RESET;
      core.right_empty_sync <= BDQ_SYNC_LOW_RESET;
      core.right_ae_sync <= BDQ_SYNC_LOW_RESET;
      core.forward_mailbox <= BDQ_DATA_RESET;
      core.reverse_mailbox <= BDQ_DATA_RESET;
      core.left_out_reg <= BDQ_DATA_RESET;
      core.right_out_reg <= BDQ_DATA_RESET;
      core.fwd_mail_flag_n <= BDQ_MAIL_FLAG_RESET;
      core.rev_mail_flag_n <= BDQ_MAIL_FLAG_RESET;
    end
    else
    begin
      core <= next_core;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // full flags show the second stage, high two edges after reset
  assign left_full_n = core.left_full_sync[1];
  assign left_almost_full_n = core.left_af_sync[1];
  assign left_empty_n = core.left_empty_sync[1];
  assign left_almost_empty_n = core.left_ae_sync[1];
  assign right_full_n = core.right_full_sync[1];
  assign right_almost_full_n = core.right_af_sync[1];
  assign right_empty_n = core.right_empty_sync[1];
  assign right_almost_empty_n = core.right_ae_sync[1];
  assign fwd_mail_flag_n = core.fwd_mail_flag_n;
  assign rev_mail_flag_n = core.rev_mail_flag_n;

  // left drives only with select and read both low
  assign left_data_oe_n = left_chip_select_n || left_write_not_read;
  // mailbox select picks the reverse mailbox
  assign left_data_out = left_mailbox_select ? core.reverse_mailbox : core.left_out_reg;
  // right drives only with select and read both low
  assign right_data_oe_n = right_chip_select_n || right_write_not_read;
  // mailbox mode shows the forward mailbox
  assign right_data_out = right_mailbox_select ? core.forward_mailbox : core.right_out_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_full_rise_edge: assert property ($rose(left_full_n) |-> $past(left_edge))
    else $error("left full flag rose without a left edge");
  a_offset_load_value: assert property (
    (core.offset_loaded && !$past(core.offset_loaded)) |->
    core.offset == bdq_offset_decode($past(offset_select_hi), $past(offset_select_lo)))
    else $error("offset not taken from the select inputs");
  a_left_mail_drive: assert property (
    (!left_data_oe_n && left_mailbox_select && $past(rev_mail_write))
    |-> left_data_out == $past(right_data_in))
    else $error("left bus not showing reverse mailbox");
  a_fwd_write_count: assert property (
    (fwd_push && fwd_in_ready && !(fwd_pop && fwd_out_valid)) |=>
    fwd_count == 7'($past(fwd_count) + 7'h01))
    else $error("forward write did not add a word");
  a_rev_mail_read: assert property (
    (rev_mail_read && !rev_mail_write) |=> rev_mail_flag_n)
    else $error("reverse mailbox read did not raise its flag");
  a_idle_no_move: assert property (
    !left_port_enable |=> $stable(core.left_out_reg) && $stable(core.forward_mailbox))
    else $error("left port moved with enable low");
  a_empty_step_edge: assert property (
    $changed(right_empty_n) |-> $past(right_edge))
    else $error("right empty flag moved off its port edge");
  a_empty_blocks_read: assert property (
    (left_access && !left_write_not_read && !left_mailbox_select && !left_empty_n)
    |=> $stable(core.left_out_reg))
    else $error("read while empty changed output register");
  a_full_blocks_write: assert property (
    (left_access && left_write_not_read && !left_mailbox_select && !left_full_n)
    |=> fwd_count <= $past(fwd_count))
    else $error("write accepted while full");
  a_mail_write_lock: assert property (
    fwd_mail_write |=> !fwd_mail_flag_n ##1 (fwd_mail_flag_n || $stable(core.forward_mailbox)))
    else $error("forward mailbox not locked after write");

  c_fwd_fill_full: cover property (fwd_count == BDQ_COUNT_FULL);
  c_rev_round_trip: cover property (rev_push ##[1:40] rev_pop);
  c_mail_exchange: cover property (fwd_mail_write ##[1:40] fwd_mail_read);
  c_almost_empty_rise: cover property ($rose(right_almost_empty_n));

endmodule : bdq_ports

// file: bdq_ports_test.sv
// Self-checking bench for the bidirectional queue port block
`timescale 1ns/1ns
module bdq_ports_test;
  import bdq_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] fsel = 2'h0;
  logic [3:0] lctl = 4'h8;
  logic [3:0] rctl = 4'h8;
  logic rhi = 1'b1;
  logic [35:0] ld = 36'h0;
  logic [35:0] rd = 36'h0;
  logic lclk, rclk, l_oe_n, r_oe_n;
  logic [35:0] lq, rq, lbus, rbus;
  logic lf, laf, le, lae, rf, raf, re, rae, mf, mr;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  int wcnt = 0;

  always #5 clk = ~clk;

  bdq_ports u_bdq_ports (
    .clk(clk), .reset_n(reset_n), .left_port_clock(lclk), .right_port_clock(rclk),
    .offset_select_lo(fsel[0]), .offset_select_hi(fsel[1]),
    .left_chip_select_n(lctl[3]), .left_write_not_read(lctl[2]),
    .left_port_enable(lctl[1]), .left_mailbox_select(lctl[0]),
    .left_data_in(ld), .left_data_out(lq), .left_data_oe_n(l_oe_n),
    .right_chip_select_n(rctl[3]), .right_write_not_read(rctl[2]),
    .right_port_enable(rctl[1]), .right_size_select_lo(rctl[0]), .right_size_select_hi(rhi),
    .right_data_in(rd), .right_data_out(rq), .right_data_oe_n(r_oe_n),
    .left_full_n(lf), .left_almost_full_n(laf), .left_empty_n(le), .left_almost_empty_n(lae),
    .right_full_n(rf), .right_almost_full_n(raf), .right_empty_n(re),
    .right_almost_empty_n(rae), .fwd_mail_flag_n(mf), .rev_mail_flag_n(mr)
  );
  bdq_port_host #(.HALF(2)) u_bdq_port_host_left (.clk(clk), .data_out(lq),
    .data_oe_n(l_oe_n), .port_clock(lclk), .bus_level(lbus));
  bdq_port_host #(.HALF(3)) u_bdq_port_host_right (.clk(clk), .data_out(rq),
    .data_oe_n(r_oe_n), .port_clock(rclk), .bus_level(rbus));

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic pneg(input bit s);
    if (s)
      @(negedge rclk);
    else
      @(negedge lclk);
  endtask : pneg

  task automatic wait_edge(input bit s);
    if (s)
      @(posedge rclk);
    else
      @(posedge lclk);
    @(posedge clk);
    // End off the launching edge so flags are read settled
    @(negedge clk);
  endtask : wait_edge

  // Controls are {chip_select_n, write_not_read, enable, mailbox}
  task automatic op(input bit s, input logic [3:0] c, input logic [35:0] d);
    pneg(s);
    if (s)
    begin
      rctl = c;
      rd = d;
    end
    else
    begin
      lctl = c;
      ld = d;
    end
    wait_edge(s);
    pneg(s);
    // Drop only the enable so a read keeps the bus driven for the check
    if (s)
      rctl[1] = 1'b0;
    else
      lctl[1] = 1'b0;
  endtask : op

  // Flags lag two port edges; the slower right clock bounds the wait
  task automatic settle();
    repeat (4) wait_edge(1);
  endtask : settle

  task automatic wr(input int n);
    repeat (n)
    begin
      op(0, 4'h6, 36'(wcnt));
      wcnt++;
    end
  endtask : wr

  task automatic do_reset(input logic [1:0] fs);
    @(negedge clk);
    reset_n = 1'b0;
    fsel = fs;
    #1;
    chk({lf, rf, le, re, lae, rae, laf, raf, mf, mr}, 10'h00F);
    repeat (5) @(posedge rclk);
    @(negedge lclk);
    reset_n = 1'b1;
    wait_edge(0);
    chk(lf, 0);
    wait_edge(0);
    chk(lf, 1);
    wait_edge(1);
    wait_edge(1);
    chk(rf, 1);
  endtask : do_reset

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      do_reset(2'(i));
      wcnt = 0;
      wr(4 * (i + 1));
      settle();
      chk(rae, 0);
      chk(re, 1);
      wr(1);
      settle();
      chk(rae, 1);
    end
    wr(30);
    settle();
    chk(laf, 1);
    wr(1);
    settle();
    chk(laf, 0);
    wr(15);
    settle();
    chk(lf, 1);
    wr(1);
    settle();
    chk(lf, 0);
    op(0, 4'h6, 36'hF_FFFF_FFFF);
    // Both size selects low still address the queues
    rhi = 1'b0;
    for (int j = 0; j < 64; j++)
    begin
      op(1, 4'h2, 36'h0);
      chk(rbus, 36'(j));
    end
    settle();
    chk(re, 0);
    op(1, 4'h2, 36'h0);
    chk(rbus, 36'h3F);
    chk(lf, 1);
    op(1, 4'h4, 36'h5_A5A5_A5A5);
    for (int j = 0; j < 3; j++)
      op(1, 4'h7, 36'hA_0000_0000 + 36'(j));
    settle();
    chk({le, lae}, 2'h2);
    for (int j = 0; j < 3; j++)
    begin
      op(0, 4'h2, 36'h0);
      chk(lbus, 36'hA_0000_0000 + 36'(j));
    end
    settle();
    chk(le, 0);
    op(0, 4'h2, 36'h0);
    chk(lbus, 36'hA_0000_0002);
    rhi = 1'b1;
    op(0, 4'h7, 36'h1_2345_6789);
    chk(mf, 0);
    op(0, 4'h7, 36'h0_DEAD_BEEF);
    op(1, 4'h3, 36'h0);
    chk(rbus, 36'h1_2345_6789);
    chk(mf, 1);
    // Left idles on its mailbox view so the right write shows through
    lctl = 4'h1;
    op(1, 4'h7, 36'h9_8765_4321);
    chk(mr, 0);
    op(0, 4'h3, 36'h0);
    chk(lbus, 36'h9_8765_4321);
    chk(mr, 1);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk);
      lctl = {2'(i), 2'h0};
      rctl = {2'(i), 2'h0};
      #1;
      chk({l_oe_n, r_oe_n}, (i == 0) ? 2'h0 : 2'h3);
    end
    test_done();
  end

  // Hang guard, far above the under three thousand cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      $display("[FAIL] %0t timeout", $time);
      test_done();
    end
  end
endmodule : bdq_ports_test
